//--- qaw_pkg.sv
package qaw_pkg;
  localparam logic [1:0] ANSWER_COUNTDOWN_RESET = 2'h3;
  localparam logic [2:0] ANSWERS_IN_WINDOW1 = 3'h3;
  localparam logic [2:0] ANSWERS_PER_SEQUENCE = 3'h4;
  localparam int FAIL_COUNT_WIDTH = 3;
  localparam int QUESTION_WIDTH = 4;
  localparam logic [FAIL_COUNT_WIDTH-1:0] FAIL_COUNT_RESET = 3'h0;
  localparam logic [QUESTION_WIDTH-1:0] QUESTION_RESET = 4'h0;

  typedef enum logic [1:0] {
    QAW_WINDOW1 = 2'b01,
    QAW_WINDOW2 = 2'b10
  } qaw_state_t;
endpackage : qaw_pkg

//--- qaw_outcome.sv
`timescale 1ns/1ps
module qaw_outcome #(
  parameter int FAIL_W = qaw_pkg::FAIL_COUNT_WIDTH,
  parameter int QUES_W = qaw_pkg::QUESTION_WIDTH
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // answer byte strobe with its compare result
  input wire logic answer_valid_in,
  input wire logic answer_correct_in,
  // window timer events
  input wire logic window1_end_in,
  input wire logic window2_end_in,
  // host write-one-to-clear strobes
  input wire logic clear_wrong_in,
  input wire logic clear_premature_in,
  input wire logic clear_sequence_in,
  input wire logic clear_timeout_in,
  // status flags
  output logic wrong_answer_flag_out,
  output logic premature_answer_flag_out,
  output logic sequence_error_flag_out,
  output logic timeout_flag_out,
  output logic bad_sequence_flag_out,
  // sequence state
  output logic [1:0] answer_countdown_out,
  output logic window2_active_out,
  output logic cycle_restart_out,
  output logic [FAIL_W-1:0] fail_count_out,
  output logic [QUES_W-1:0] question_out
);

  function automatic logic [1:0] qaw_countdown(input logic [2:0] received);
    qaw_countdown = 2'(qaw_pkg::ANSWER_COUNTDOWN_RESET - received[1:0]);
  endfunction : qaw_countdown

  qaw_pkg::qaw_state_t state;
  logic [2:0] received;
  logic [2:0] next_received;
  logic wrong_now;
  logic end_early;
  logic close_w1;
  logic late_w1;
  logic done_w2;
  logic close_w2;
  logic seq_end;
  logic seq_fail;

  always_comb begin
    next_received = received + 3'(answer_valid_in);
    wrong_now = answer_valid_in & ~answer_correct_in;
    end_early = (state == qaw_pkg::QAW_WINDOW1) &&
                (next_received == qaw_pkg::ANSWERS_PER_SEQUENCE);
    // an answer in the same cycle as a window end counts in that window
    close_w1 = (state == qaw_pkg::QAW_WINDOW1) && window1_end_in && !end_early;
    late_w1 = close_w1 && (next_received < qaw_pkg::ANSWERS_IN_WINDOW1);
    done_w2 = (state == qaw_pkg::QAW_WINDOW2) &&
              (next_received == qaw_pkg::ANSWERS_PER_SEQUENCE);
    close_w2 = (state == qaw_pkg::QAW_WINDOW2) && window2_end_in && !done_w2;
    seq_end = end_early | done_w2 | close_w2;
    seq_fail = bad_sequence_flag_out | wrong_now | end_early | close_w2;
  end

  // window sequencing
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state <= qaw_pkg::QAW_WINDOW1;
    end else begin
      case (state)
        qaw_pkg::QAW_WINDOW1: begin
          if (close_w1) begin
            state <= qaw_pkg::QAW_WINDOW2;
          end
        end
        qaw_pkg::QAW_WINDOW2: begin
          if (seq_end) begin
            state <= qaw_pkg::QAW_WINDOW1;
          end
        end
        default: state <= qaw_pkg::QAW_WINDOW1;
      endcase
    end
  end

  // answer counting
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      received <= 3'h0;
      answer_countdown_out <= qaw_pkg::ANSWER_COUNTDOWN_RESET;
    end else if (seq_end) begin
      received <= 3'h0;
      answer_countdown_out <= qaw_pkg::ANSWER_COUNTDOWN_RESET;
    end else begin
      received <= next_received;
      answer_countdown_out <= qaw_countdown(next_received);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      window2_active_out <= 1'b0;
      cycle_restart_out <= 1'b0;
    end else begin
      window2_active_out <= (state == qaw_pkg::QAW_WINDOW2) ? !seq_end
                                                            : close_w1;
      cycle_restart_out <= seq_end;
    end
  end

  // status flags: a set in the clearing cycle wins
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      wrong_answer_flag_out <= 1'b0;
      premature_answer_flag_out <= 1'b0;
      sequence_error_flag_out <= 1'b0;
      timeout_flag_out <= 1'b0;
    end else begin
      wrong_answer_flag_out <= (wrong_answer_flag_out & ~clear_wrong_in) |
                               wrong_now;
      // early only on four in window one
      premature_answer_flag_out <=
        (premature_answer_flag_out & ~clear_premature_in) | end_early;
      sequence_error_flag_out <=
        (sequence_error_flag_out & ~clear_sequence_in) | late_w1;
      timeout_flag_out <= (timeout_flag_out & ~clear_timeout_in) | close_w2;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      bad_sequence_flag_out <= 1'b0;
    end else if (seq_end) begin
      bad_sequence_flag_out <= 1'b0;
    end else begin
      bad_sequence_flag_out <= bad_sequence_flag_out | wrong_now | late_w1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      fail_count_out <= FAIL_W'(qaw_pkg::FAIL_COUNT_RESET);
      question_out <= QUES_W'(qaw_pkg::QUESTION_RESET);
    end else if (seq_end && seq_fail) begin
      // saturate so a long outage cannot wrap back to a clean count
      if (fail_count_out != {FAIL_W{1'b1}}) begin
        fail_count_out <= fail_count_out + FAIL_W'(1);
      end
    end else if (seq_end) begin
      if (fail_count_out != '0) begin
        fail_count_out <= fail_count_out - FAIL_W'(1);
      end
      question_out <= question_out + QUES_W'(1);
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  a_silent_timeout: assert property (
    (state == qaw_pkg::QAW_WINDOW2) && window2_end_in && !answer_valid_in &&
    (received == 3'h0) |=> timeout_flag_out && cycle_restart_out &&
    (state == qaw_pkg::QAW_WINDOW1))
    else $error("silent sequence did not time out");

  a_fourth_restart: assert property (
    (state == qaw_pkg::QAW_WINDOW2) && answer_valid_in && (received == 3'h3)
    && !timeout_flag_out |=> cycle_restart_out && !timeout_flag_out)
    else $error("fourth late answer did not restart cleanly");

  a_short_close: assert property (
    close_w2 |=> timeout_flag_out ##0 cycle_restart_out ##1 !cycle_restart_out)
    else $error("window two close without restart");

  a_late_wrong: assert property (
    (state == qaw_pkg::QAW_WINDOW2) && wrong_now |=> wrong_answer_flag_out)
    else $error("wrong late answer not flagged");

  a_early_wrong: assert property (
    (state == qaw_pkg::QAW_WINDOW1) && wrong_now && !end_early
    |=> wrong_answer_flag_out && bad_sequence_flag_out)
    else $error("wrong early answer not flagged");

  a_fail_step: assert property (
    (state == qaw_pkg::QAW_WINDOW2) && seq_end && bad_sequence_flag_out &&
    (fail_count_out != {FAIL_W{1'b1}})
    |=> fail_count_out == $past(fail_count_out) + FAIL_W'(1) &&
    question_out == $past(question_out))
    else $error("short window did not raise fail count");

  a_no_early: assert property (
    (state == qaw_pkg::QAW_WINDOW2) |=> !$rose(premature_answer_flag_out))
    else $error("early flag raised in window two");

  a_three_late: assert property (
    (state == qaw_pkg::QAW_WINDOW2) && (received == 3'h3) && !answer_valid_in
    && window2_end_in |=> timeout_flag_out && cycle_restart_out &&
    (state == qaw_pkg::QAW_WINDOW1))
    else $error("three late answers not timed out");

  a_seq_latch: assert property (
    late_w1 |=> sequence_error_flag_out && bad_sequence_flag_out)
    else $error("short first window not flagged");

  a_flag_hold: assert property (
    sequence_error_flag_out && !clear_sequence_in |=> sequence_error_flag_out)
    else $error("sequence error dropped without clear");

  a_bad_clear: assert property (
    cycle_restart_out |-> !bad_sequence_flag_out)
    else $error("bad flag survived sequence end");

  c_good_sequence: cover property (
    seq_end && !seq_fail ##1 question_out != $past(question_out));
  c_early_four: cover property (end_early ##1 premature_answer_flag_out);
  c_late_fourth: cover property (late_w1 ##[1:40] done_w2);
endmodule : qaw_outcome

//--- qaw_host.sv
`timescale 1ns/1ps
module qaw_host (
  // clock
  input wire logic clk_sys_in,
  // answer bytes and window events
  output logic answer_valid_out,
  output logic answer_correct_out,
  output logic window1_end_out,
  output logic window2_end_out
);
  initial begin
    answer_valid_out = 1'b0;
    answer_correct_out = 1'b0;
    window1_end_out = 1'b0;
    window2_end_out = 1'b0;
  end
  task automatic answer(input logic ok);
    @(negedge clk_sys_in);
    answer_valid_out = 1'b1;
    answer_correct_out = ok;
    @(negedge clk_sys_in);
    answer_valid_out = 1'b0;
    // the compare line means nothing between bytes
    answer_correct_out = ~ok;
  endtask : answer
  task automatic win1(input int n, input logic [3:0] bad);
    for (int i = 0; i < n; i++) answer(~bad[i]);
    @(negedge clk_sys_in);
    window1_end_out = 1'b1;
    @(negedge clk_sys_in);
    window1_end_out = 1'b0;
  endtask : win1
  // late bytes; window two only ends when short
  task automatic win2(input int n1, input int n2, input logic [3:0] bad);
    for (int i = 0; i < n2; i++) answer(~bad[n1+i]);
    if (n1 + n2 < 4) begin
      @(negedge clk_sys_in);
      window2_end_out = 1'b1;
      @(negedge clk_sys_in);
      window2_end_out = 1'b0;
    end
  endtask : win2
endmodule : qaw_host

//--- qaw_watchdog_window_outcomes_tb.sv
`timescale 1ns/1ps
module qaw_watchdog_window_outcomes_tb;
  typedef struct packed {
    logic [2:0] n1;
    logic [2:0] n2;
    logic [3:0] bad;
    logic wrong;
    logic tmo;
  } qaw_row_t;
  logic clk_sys_in, nrst_in, av, ac, w1, w2, cw, cp, cs, ct;
  logic wf, pf, sf, tf, bf, w2a, rs;
  logic [1:0] cd;
  logic [2:0] fc, fail_exp;
  logic [3:0] q;
  int errors = 0;
  int n_tests = 0;
  qaw_row_t rows [10];
  qaw_outcome qaw_outcome_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .answer_valid_in(av), .answer_correct_in(ac), .window1_end_in(w1),
    .window2_end_in(w2), .clear_wrong_in(cw), .clear_premature_in(cp),
    .clear_sequence_in(cs), .clear_timeout_in(ct),
    .wrong_answer_flag_out(wf), .premature_answer_flag_out(pf),
    .sequence_error_flag_out(sf), .timeout_flag_out(tf),
    .bad_sequence_flag_out(bf), .answer_countdown_out(cd),
    .window2_active_out(w2a), .cycle_restart_out(rs),
    .fail_count_out(fc), .question_out(q));
  qaw_host qaw_host_inst (.clk_sys_in(clk_sys_in), .answer_valid_out(av),
    .answer_correct_out(ac), .window1_end_out(w1), .window2_end_out(w2));
  task automatic chk(input string nm, input logic [3:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask : chk
  task automatic conclude();
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic clr(input logic [3:0] m);
    @(negedge clk_sys_in);
    {cw, cp, cs, ct} = m;
    @(negedge clk_sys_in);
    {cw, cp, cs, ct} = 4'h0;
  endtask : clr
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    errors++;
    conclude();
  end
  initial begin
    nrst_in = 1'b0;
    {cw, cp, cs, ct} = 4'h0;
    fail_exp = 3'h0;
    rows = '{
      '{3'h0, 3'h0, 4'h0, 1'b0, 1'b1}, '{3'h0, 3'h4, 4'hf, 1'b1, 1'b0},
      '{3'h0, 3'h4, 4'h0, 1'b0, 1'b0}, '{3'h1, 3'h1, 4'h0, 1'b0, 1'b1},
      '{3'h2, 3'h1, 4'h4, 1'b1, 1'b1}, '{3'h1, 3'h3, 4'h0, 1'b0, 1'b0},
      '{3'h2, 3'h2, 4'hc, 1'b1, 1'b0}, '{3'h0, 3'h3, 4'h0, 1'b0, 1'b1},
      '{3'h1, 3'h2, 4'h1, 1'b1, 1'b1}, '{3'h2, 3'h2, 4'h3, 1'b1, 1'b0}};
    repeat (16) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    chk("countdown", {2'h0, cd}, 4'h3);
    chk("flags", {wf, pf, sf, tf}, 4'h0);
    foreach (rows[i]) begin
      qaw_host_inst.win1(rows[i].n1, rows[i].bad);
      chk("seq_w1", {2'h0, sf, bf}, 4'h3);
      chk("window2", {3'h0, w2a}, 4'h1);
      chk("countdown_w1", {2'h0, 2'h3 - rows[i].n1[1:0]}, {2'h0, cd});
      qaw_host_inst.win2(rows[i].n1, rows[i].n2, rows[i].bad);
      fail_exp = (fail_exp == 3'h7) ? 3'h7 : fail_exp + 3'h1;
      chk("restart", {3'h0, rs}, 4'h1);
      chk("restart_state", {1'b0, w2a, cd}, 4'h3);
      chk("wrong", {3'h0, wf}, {3'h0, rows[i].wrong});
      chk("premature", {3'h0, pf}, 4'h0);
      chk("seq", {3'h0, sf}, 4'h1);
      chk("timeout", {3'h0, tf}, {3'h0, rows[i].tmo});
      chk("bad_end", {3'h0, bf}, 4'h0);
      chk("fail", {1'b0, fc}, {1'b0, fail_exp});
      chk("question", q, qaw_pkg::QUESTION_RESET);
      clr(4'h1);
      chk("clear_one", {2'h0, sf, tf}, 4'h2);
      clr(4'he);
      chk("clear_all", {wf, pf, sf, tf}, 4'h0);
    end
    // a clean sequence steps the question and lowers the count
    qaw_host_inst.win1(3, 4'h0);
    chk("good_w1", {wf, sf, bf, w2a}, 4'h1);
    chk("good_cd", {2'h0, cd}, 4'h0);
    qaw_host_inst.win2(3, 1, 4'h0);
    chk("good_end", {rs, sf, tf, wf}, 4'h8);
    chk("good_fail", {1'b0, fc}, 4'h6);
    chk("good_question", q, qaw_pkg::QUESTION_RESET + 4'h1);
    // a clear in the cycle of a wrong answer loses to the set
    fork
      qaw_host_inst.answer(1'b0);
      clr(4'h8);
    join
    repeat (3) qaw_host_inst.answer(1'b1);
    chk("early_end", {rs, pf, wf, bf}, 4'he);
    chk("early_fail", {1'b0, fc}, 4'h7);
    chk("early_question", q, qaw_pkg::QUESTION_RESET + 4'h1);
    // reset in mid-run must drop the saturated count
    @(negedge clk_sys_in);
    nrst_in = 1'b0;
    @(negedge clk_sys_in);
    nrst_in = 1'b1;
    chk("fail_reset", {1'b0, fc}, 4'h0);
    chk("reset_flags", {wf, pf, rs, bf}, 4'h0);
    chk("reset_question", q, qaw_pkg::QUESTION_RESET);
    chk("reset_state", {1'b0, w2a, cd}, 4'h3);
    conclude();
  end
endmodule : qaw_watchdog_window_outcomes_tb
